// File: hdl/uwt_defs.svh
/*
 * Constants of the serial port: register byte offsets, field positions,
 * reset values and baud prescaler figures.
 * Assumes the includer only needs macro definitions, no logic.
 */
`ifndef UWT_DEFS_SVH
`define UWT_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets (AHB word aligned)
// ----------------------------------------------------------------------
`define UWT_ADDR_CTRL     8'h00
`define UWT_ADDR_DATA     8'h04
`define UWT_ADDR_BAUD     8'h08
`define UWT_ADDR_COUNT    8'h0C
`define UWT_ADDR_ISTAT    8'h10
`define UWT_ADDR_IMASK    8'h14

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define UWT_CTRL_MODE     7
`define UWT_CTRL_ONE      6
`define UWT_CTRL_MCE      5
`define UWT_CTRL_REN      4
`define UWT_CTRL_TB8      3
`define UWT_CTRL_RB8      2
`define UWT_CTRL_TI       1
`define UWT_CTRL_RI       0
`define UWT_CTRL_RESET    8'h40

// ----------------------------------------------------------------------
// Baud register fields: reload [7:0], source [10:8], run [11]
// ----------------------------------------------------------------------
`define UWT_BAUD_SEL_LO   8
`define UWT_BAUD_RUN      11
`define UWT_BAUD_RESET    12'h000

// ----------------------------------------------------------------------
// Interrupt status and mask fields
// ----------------------------------------------------------------------
`define UWT_INT_TX        1
`define UWT_INT_RX        0

// ----------------------------------------------------------------------
// Timer figures
// ----------------------------------------------------------------------
`define UWT_PRE_LAST      6'd47
`define UWT_OSC_DIV_LAST  3'd7
`define UWT_TMR_TOP       8'hFF
`define UWT_DATA_BITS     4'd8

`endif

// File: hdl/uwt_pkg.sv
/*
 * Types shared by the serial port modules: state machines and the baud
 * timer clock source selection.
 * Assumes uwt_defs.svh carries all numeric constants.
 */
package uwt_pkg;

    // Baud timer clock sources
    typedef enum logic [2:0] {
        UWT_SRC_SYS    = 3'b000,
        UWT_SRC_DIV4   = 3'b001,
        UWT_SRC_DIV12  = 3'b010,
        UWT_SRC_DIV48  = 3'b011,
        UWT_SRC_OSC8   = 3'b100,
        UWT_SRC_EXTIN  = 3'b101
    } uwt_clksel_t;

    // Transmitter states
    typedef enum logic [2:0] {
        UWT_TX_IDLE  = 3'b000,
        UWT_TX_START = 3'b001,
        UWT_TX_DATA  = 3'b010,
        UWT_TX_NINTH = 3'b011,
        UWT_TX_STOP  = 3'b100
    } uwt_tx_state_t;

    // Receiver states
    typedef enum logic [2:0] {
        UWT_RX_IDLE  = 3'b000,
        UWT_RX_START = 3'b001,
        UWT_RX_DATA  = 3'b010,
        UWT_RX_NINTH = 3'b011,
        UWT_RX_STOP  = 3'b100
    } uwt_rx_state_t;

endpackage

// File: hdl/uwt_baud.sv
/*
 * Baud timer: prescaler, 8-bit auto-reload transmit counter and hidden
 * receive counter copy.
 * Assumes pins ext_osc_pin and ext_in_pin are asynchronous to ref_clk.
 */
`timescale 1ns/100ps
`include "uwt_defs.svh"

module uwt_baud (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rst,
    // Configuration
    input  wire logic               run,
    input  wire uwt_pkg::uwt_clksel_t clk_sel,
    input  wire logic [7:0]         reload,
    // Pins
    input  wire logic               ext_osc_pin,
    input  wire logic               ext_in_pin,
    // Receiver handshake
    input  wire logic               rx_restart,
    // Results
    output logic                    tx_bit_tick,
    output logic                    rx_ovf,
    output logic [7:0]              low_count
);
    import uwt_pkg::*;

    logic [5:0] pre_q;
    logic [2:0] osc_div_q;
    logic [2:0] osc_sync_q;
    logic [2:0] ext_sync_q;
    logic       osc_tick_q;
    logic       tick;
    logic [7:0] rx_cnt_q;
    logic       tx_half_q;

    // ------------------------------------------------------------------
    // Prescaler and pin synchronisers
    // ------------------------------------------------------------------

    // Free running divider, 0..47, shared by the /4, /12 and /48 taps
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pre_q <= 6'd0;
        end else if (pre_q == `UWT_PRE_LAST) begin
            pre_q <= 6'd0;
        end else begin
            pre_q <= pre_q + 6'd1;
        end
    end

    // Two flops per pin, third flop only for edge detection
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            osc_sync_q <= 3'b000;
            ext_sync_q <= 3'b111;
        end else begin
            osc_sync_q <= {osc_sync_q[1:0], ext_osc_pin};
            ext_sync_q <= {ext_sync_q[1:0], ext_in_pin};
        end
    end

    // Oscillator runs on its own, so system clock stays independent
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            osc_div_q  <= 3'd0;
            osc_tick_q <= 1'b0;
        end else begin
            osc_tick_q <= 1'b0;
            if (osc_sync_q[1] && !osc_sync_q[2]) begin
                osc_div_q  <= osc_div_q + 3'd1;
                osc_tick_q <= (osc_div_q == `UWT_OSC_DIV_LAST);
            end
        end
    end

    // Six selectable timer clock sources
    always_comb begin
        unique case (clk_sel)
            UWT_SRC_SYS:   tick = 1'b1;
            UWT_SRC_DIV4:  tick = (pre_q[1:0] == 2'b11);
            UWT_SRC_DIV12: tick = (pre_q == 6'd11) || (pre_q == 6'd23) ||
                                  (pre_q == 6'd35) || (pre_q == `UWT_PRE_LAST);
            UWT_SRC_DIV48: tick = (pre_q == `UWT_PRE_LAST);
            UWT_SRC_OSC8:  tick = osc_tick_q;
            UWT_SRC_EXTIN: tick = !ext_sync_q[1] && ext_sync_q[2];
            default:       tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------------

    // Transmit counter, auto-reload: overflow every 256 - reload ticks
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            low_count   <= 8'h00;
            tx_half_q   <= 1'b0;
            tx_bit_tick <= 1'b0;
        end else begin
            tx_bit_tick <= 1'b0;
            if (run && tick) begin
                if (low_count == `UWT_TMR_TOP) begin
                    low_count   <= reload;
                    tx_half_q   <= !tx_half_q;
                    tx_bit_tick <= tx_half_q;
                end else begin
                    low_count <= low_count + 8'd1;
                end
            end
        end
    end

    // Hidden receive copy; a start edge reloads it at once
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rx_cnt_q <= 8'h00;
            rx_ovf   <= 1'b0;
        end else begin
            rx_ovf <= 1'b0;
            if (rx_restart) begin
                rx_cnt_q <= reload;
            end else if (run && tick) begin
                if (rx_cnt_q == `UWT_TMR_TOP) begin
                    rx_cnt_q <= reload;
                    rx_ovf   <= 1'b1;
                end else begin
                    rx_cnt_q <= rx_cnt_q + 8'd1;
                end
            end
        end
    end

endmodule

// File: hdl/uwt_top.sv
/*
 * Serial port with timer baud generator, AHB-Lite register slave and a
 * level interrupt.
 * Assumes a single AHB-Lite master, ref_clk at 20 MHz, rxd asynchronous.
 */
// The implementer's own choices: register access over AHB-Lite and the placing of the registers.
// Notes on behaviour
// - Full duplex asynchronous port, 8-bit and 9-bit variable baud frames.
// - Completed byte held in buffer while next byte is being received.
// - Data address write loads transmit register, never touches received data.
// - Data address read returns buffered received byte; transmit not readable.
// - Unmasked transmit or receive done raises the interrupt.
// - Done flags stay set until software clears them.
// - Baud from 8-bit auto-reload timer; transmit uses its low counter.
// - Receive uses hidden counter copy, same reload, runs when timer runs.
// - Both counter overflows divided by two for the bit rate.
// - Start edge on receive pin forces hidden counter reload.
// - Overflow rate is timer clock over 256 minus reload; baud half.
// - Timer clock from six sources: sys, /4, /12, /48, osc/8, pin.
// - External oscillator may clock timer while system clock stays separate.
// - 8-bit frame: start, eight data LSB first, stop into ninth-bit field.
// - 9-bit frame: ninth bit from software field, received into ninth field.
// - Transmit done flag set at start of stop bit.
`timescale 1ns/100ps
`include "uwt_defs.svh"

module uwt_top (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Serial pins
    input  wire logic        rxd,
    output logic             txd,
    // Baud timer pins
    input  wire logic        ext_osc_pin,
    input  wire logic        ext_in_pin,
    // Interrupt
    output logic             irq
);
    import uwt_pkg::*;

    logic [7:0]    ctrl_q;
    logic [11:0]   baud_q;
    logic [1:0]    istat_q;
    logic [1:0]    imask_q;
    logic [7:0]    rx_buf_q;
    logic [7:0]    tx_reg_q;
    logic          tx_pend_q;
    logic [7:0]    addr_q;
    logic          wr_pend_q;
    logic          rd_pend_q;
    logic          ti_set;
    logic          ri_set;
    logic          rb8_new;
    logic          tx_bit_tick;
    logic          rx_ovf;
    logic [7:0]    low_count;
    logic          rx_restart;
    uwt_tx_state_t tx_state_q;
    logic [7:0]    tx_shift_q;
    logic [3:0]    tx_cnt_q;
    uwt_rx_state_t rx_state_q;
    logic [7:0]    rx_shift_q;
    logic [3:0]    rx_cnt_q;
    logic          rx_phase_q;
    logic [2:0]    rx_sync_q;
    logic          accept;
    logic          wr_ctrl;
    logic          wr_data;
    logic          rd_istat;
    logic          mode9;
    logic          sample;

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------

    // Address phase taken only for NONSEQ/SEQ while the bus is ready
    assign accept   = hsel && hready && htrans[1];
    assign wr_ctrl  = wr_pend_q && (addr_q == `UWT_ADDR_CTRL);
    assign wr_data  = wr_pend_q && (addr_q == `UWT_ADDR_DATA);
    assign rd_istat = rd_pend_q && (addr_q == `UWT_ADDR_ISTAT);
    assign mode9    = ctrl_q[`UWT_CTRL_MODE];

    // Reads take one wait state so read data leaves a flop
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            addr_q    <= 8'h00;
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hresp     <= 1'b0;
            wr_pend_q <= accept && hwrite;
            if (rd_pend_q) begin
                rd_pend_q <= 1'b0;
                hreadyout <= 1'b1;
            end else if (accept && !hwrite) begin
                rd_pend_q <= 1'b1;
                hreadyout <= 1'b0;
            end
            if (accept) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    // Read mux; unmapped offsets return zero, transmit register hidden
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_pend_q) begin
            unique case (addr_q)
                `UWT_ADDR_CTRL:  hrdata <= {24'h00_0000, ctrl_q};
                `UWT_ADDR_DATA:  hrdata <= {24'h00_0000, rx_buf_q};
                `UWT_ADDR_BAUD:  hrdata <= {20'h0_0000, baud_q};
                `UWT_ADDR_COUNT: hrdata <= {24'h00_0000, low_count};
                `UWT_ADDR_ISTAT: hrdata <= {30'h0000_0000, istat_q};
                `UWT_ADDR_IMASK: hrdata <= {30'h0000_0000, imask_q};
                default:         hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Baud and mask registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            baud_q  <= `UWT_BAUD_RESET;
            imask_q <= 2'b00;
        end else if (wr_pend_q) begin
            if (addr_q == `UWT_ADDR_BAUD) begin
                baud_q <= hwdata[11:0];
            end
            if (addr_q == `UWT_ADDR_IMASK) begin
                imask_q <= hwdata[1:0];
            end
        end
    end

    // Control register; hardware sets win over a software clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= `UWT_CTRL_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= {hwdata[7], 1'b1, hwdata[5:0]};
            end
            if (ti_set) begin
                ctrl_q[`UWT_CTRL_TI] <= 1'b1;
            end
            if (ri_set) begin
                ctrl_q[`UWT_CTRL_RI] <= 1'b1;
                ctrl_q[`UWT_CTRL_RB8] <= rb8_new;
            end
        end
    end

    // Transmit register load, kept apart from the receive buffer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_reg_q <= 8'h00;
        end else if (wr_data) begin
            tx_reg_q <= hwdata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------

    // Sticky events, cleared by a read of the status word
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            istat_q <= 2'b00;
            irq     <= 1'b0;
        end else begin
            istat_q <= (rd_istat ? 2'b00 : istat_q) | {ti_set, ri_set};
            irq     <= |(istat_q & imask_q);
        end
    end

    // ------------------------------------------------------------------
    // Baud generator
    // ------------------------------------------------------------------

    uwt_baud u_baud (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .run         (baud_q[`UWT_BAUD_RUN]),
        .clk_sel     (uwt_clksel_t'(baud_q[10:8])),
        .reload      (baud_q[7:0]),
        .ext_osc_pin (ext_osc_pin),
        .ext_in_pin  (ext_in_pin),
        .rx_restart  (rx_restart),
        .tx_bit_tick (tx_bit_tick),
        .rx_ovf      (rx_ovf),
        .low_count   (low_count)
    );

    // ------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------

    // Pending flag bridges a write to the next bit boundary
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_pend_q <= 1'b0;
        end else if (wr_data) begin
            tx_pend_q <= 1'b1;
        end else if (tx_state_q == UWT_TX_IDLE && tx_bit_tick) begin
            tx_pend_q <= 1'b0;
        end
    end

    // Frame: start, eight data LSB first, optional ninth, stop
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_state_q <= UWT_TX_IDLE;
            tx_shift_q <= 8'h00;
            tx_cnt_q   <= 4'd0;
            txd        <= 1'b1;
            ti_set     <= 1'b0;
        end else begin
            ti_set <= 1'b0;
            if (tx_bit_tick) begin
                unique case (tx_state_q)
                    UWT_TX_IDLE: begin
                        if (tx_pend_q) begin
                            tx_shift_q <= tx_reg_q;
                            txd        <= 1'b0;
                            tx_state_q <= UWT_TX_START;
                        end
                    end
                    UWT_TX_START, UWT_TX_DATA: begin
                        txd        <= tx_shift_q[0];
                        tx_shift_q <= {1'b0, tx_shift_q[7:1]};
                        tx_cnt_q   <= tx_cnt_q + 4'd1;
                        tx_state_q <= UWT_TX_DATA;
                        if (tx_state_q == UWT_TX_START) begin
                            tx_cnt_q <= 4'd1;
                        end else if (tx_cnt_q == `UWT_DATA_BITS) begin
                            txd        <= mode9 ? ctrl_q[`UWT_CTRL_TB8] : 1'b1;
                            tx_state_q <= mode9 ? UWT_TX_NINTH : UWT_TX_STOP;
                            ti_set     <= !mode9;
                        end
                    end
                    UWT_TX_NINTH: begin
                        txd        <= 1'b1;
                        ti_set     <= 1'b1;
                        tx_state_q <= UWT_TX_STOP;
                    end
                    UWT_TX_STOP: begin
                        tx_state_q <= UWT_TX_IDLE;
                    end
                    default: begin
                        tx_state_q <= UWT_TX_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------

    // Two flops against metastability, third only for the edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rx_sync_q <= 3'b111;
        end else begin
            rx_sync_q <= {rx_sync_q[1:0], rxd};
        end
    end

    // Falling edge while idle and enabled starts a frame
    assign rx_restart = (rx_state_q == UWT_RX_IDLE) && ctrl_q[`UWT_CTRL_REN] &&
                        baud_q[`UWT_BAUD_RUN] && !rx_sync_q[1] && rx_sync_q[2];
    // Two overflows per bit: sample on even ones, mid bit
    assign sample = rx_ovf && !rx_phase_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rx_state_q <= UWT_RX_IDLE;
            rx_shift_q <= 8'h00;
            rx_cnt_q   <= 4'd0;
            rx_phase_q <= 1'b0;
            rx_buf_q   <= 8'h00;
            ri_set     <= 1'b0;
            rb8_new    <= 1'b0;
        end else begin
            ri_set <= 1'b0;
            if (rx_restart) begin
                rx_phase_q <= 1'b0;
                rx_state_q <= UWT_RX_START;
            end else if (rx_ovf) begin
                rx_phase_q <= !rx_phase_q;
            end
            if (sample) begin
                unique case (rx_state_q)
                    UWT_RX_IDLE: begin
                    end
                    UWT_RX_START: begin
                        // Glitch shorter than half a bit is dropped
                        rx_cnt_q   <= 4'd0;
                        rx_state_q <= rx_sync_q[1] ? UWT_RX_IDLE : UWT_RX_DATA;
                    end
                    UWT_RX_DATA: begin
                        rx_shift_q <= {rx_sync_q[1], rx_shift_q[7:1]};
                        rx_cnt_q   <= rx_cnt_q + 4'd1;
                        if (rx_cnt_q == `UWT_DATA_BITS - 4'd1) begin
                            rx_state_q <= mode9 ? UWT_RX_NINTH : UWT_RX_STOP;
                        end
                    end
                    UWT_RX_NINTH: begin
                        rb8_new    <= rx_sync_q[1];
                        rx_state_q <= UWT_RX_STOP;
                    end
                    UWT_RX_STOP: begin
                        // Stop bit counts only in 8-bit mode
                        rx_state_q <= UWT_RX_IDLE;
                        if (!ctrl_q[`UWT_CTRL_RI] &&
                            (!ctrl_q[`UWT_CTRL_MCE] ||
                             (mode9 ? rb8_new : rx_sync_q[1]))) begin
                            rx_buf_q <= rx_shift_q;
                            ri_set   <= 1'b1;
                            if (!mode9) begin
                                rb8_new <= rx_sync_q[1];
                            end
                        end
                    end
                    default: begin
                        rx_state_q <= UWT_RX_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

// File: test/uwt_top_asserts.sv
/* Port checker for uwt_top.
   Assumes the bench runs the baud timer at BIT_CYC cycles a bit. */
`timescale 1ns/100ps
module uwt_chk #(parameter int BIT_CYC = 4) (
    // Clock, reset and bus
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Serial and interrupt
    input wire logic        txd,
    input wire logic        irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic       take;
    logic [5:0] lo_q;
    logic [2:0] age_q;
    assign take = hsel && hready && htrans[1];
    // Low run on txd and age of last access; age saturates so it never wraps
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lo_q  <= 6'h00;
            age_q <= 3'h0;
        end else begin
            lo_q  <= txd ? 6'h00 : lo_q + 6'h01;
            age_q <= take ? 3'h0 : ((age_q == 3'h7) ? age_q : age_q + 3'h1);
        end
    end
    sequence s_rd_take;
        take && !hwrite;
    endsequence
    sequence s_rd_answer;
        !hreadyout ##1 hreadyout;
    endsequence
    a_read_wait: assert property (s_rd_take |=> s_rd_answer)
        else $error("read wait not one cycle");
    a_write_zero: assert property (take && hwrite |=> hreadyout)
        else $error("write got a wait");
    a_wait_cause: assert property (!hreadyout |-> $past(take && !hwrite))
        else $error("wait without read");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("read data moved");
    a_irq_fall: assert property ($fell(irq) |-> age_q < 3'h6)
        else $error("irq fell without access");
    a_low_bits: assert property ($rose(txd) |-> (lo_q % BIT_CYC) == 0)
        else $error("low run not whole bits");
    a_low_max: assert property ($rose(txd) |-> lo_q <= 6'd40)
        else $error("low run too long");
endmodule

bind uwt_top uwt_chk #(.BIT_CYC(4)) uwt_chk_i (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .txd(txd), .irq(irq));

// File: test/uwt_remote.sv
/* Remote serial station: sends frames on rxd, decodes frames on txd.
   Assumes bits of BIT_CYC clocks and an idle-high line. */
`timescale 1ns/100ps
module uwt_remote #(parameter int BIT_CYC = 4) (
    // Clock and link
    input  wire logic ref_clk,
    input  wire logic txd,
    input  wire logic nine,
    output logic      rxd,
    // Last decoded frame
    output logic [8:0] got
);
    initial begin
        rxd = 1'b1;
        got = 9'h000;
    end
    // One frame: start, data LSB first, ninth in 9-bit mode, stop
    task automatic send(input logic [8:0] w);
        int n;
        n = nine ? 11 : 10;
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            rxd <= (i == 0) ? 1'b0 : ((i == n - 1) ? 1'b1 : w[i-1]);
            repeat (BIT_CYC - 1) @(posedge ref_clk);
        end
    endtask
    // Mid-bit sampling; stop level in 8-bit mode is not kept
    always begin
        @(negedge txd);
        repeat (BIT_CYC / 2) @(posedge ref_clk);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT_CYC) @(posedge ref_clk);
            got[i] = (i < 8 || nine) ? txd : 1'b0;
        end
        repeat (BIT_CYC) @(posedge ref_clk);
    end
endmodule

// File: test/tb_uwt_top.sv
/* Bench for uwt_top: register table, then frames both ways.
   Assumes uwt_remote at the serial side and uwt_chk bound in. */
`timescale 1ns/100ps
module tb_uwt_top;
    typedef struct packed {logic [7:0] a; logic w; logic [31:0] d;} uwt_row_t;
    logic        ref_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
    logic        rxd, txd, irq, nine, osc, tin;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [8:0]  got;
    int          bad_count = 0;
    int          n_checks = 0;
    // Address, write, data or expected read
    uwt_row_t    rows[12] = '{'{8'h00, 0, 32'h40}, '{8'h08, 0, 32'h0}, '{8'h10, 0, 32'h0},
        '{8'h14, 0, 32'h0}, '{8'h18, 1, 32'hFFFF}, '{8'h18, 0, 32'h0}, '{8'h14, 1, 32'h3},
        '{8'h14, 0, 32'h3}, '{8'h08, 1, 32'h8FE}, '{8'h08, 0, 32'h8FE},
        '{8'h00, 1, 32'h10}, '{8'h00, 0, 32'h50}};
    assign hready = hreadyout;
    uwt_top uwt_top_i (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .rxd(rxd), .txd(txd), .ext_osc_pin(osc), .ext_in_pin(tin), .irq(irq));
    uwt_remote uwt_remote_i (.ref_clk(ref_clk), .txd(txd), .nine(nine), .rxd(rxd), .got(got));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Bounded wait for hready (s=0) or irq (s=1); running out ends the run
    task automatic hold(input bit s, input int n);
        @(posedge ref_clk);
        for (int i = 0; i < n && (s ? irq : hready) !== 1'b1; i++) @(posedge ref_clk);
        if ((s ? irq : hready) !== 1'b1) begin
            bad_count++;
            report_and_stop();
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        hold(0, 9);
        htrans <= 2'h0;
        hwdata <= d;
        hold(0, 9);
        q = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0000_0000);
        chk(q, e);
    endtask
    initial begin
        {rst, hsel, hwrite, nine, htrans, haddr, hwdata} = {1'b1, 69'h0};
        {hsize, osc, tin} = 5'h09;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        foreach (rows[k]) begin
            bus(rows[k].a, rows[k].w, rows[k].d);
            if (!rows[k].w) chk(q, rows[k].d);
        end
        bus(8'h04, 1'b1, 32'h0000_00A5);
        hold(1, 300);
        repeat (8) @(posedge ref_clk);
        chk({23'h0, got}, 32'h0000_00A5);
        rd(8'h00, 32'h0000_0052);
        rd(8'h10, 32'h0000_0002);
        bus(8'h00, 1'b1, 32'h0000_0010);
        uwt_remote_i.send(9'h03C);
        hold(1, 20);
        rd(8'h04, 32'h0000_003C);
        rd(8'h00, 32'h0000_0055);
        // Transmit runs while the next frame arrives
        bus(8'h04, 1'b1, 32'h0000_0077);
        uwt_remote_i.send(9'h0AA);
        rd(8'h04, 32'h0000_003C);
        repeat (8) @(posedge ref_clk);
        chk({23'h0, got}, 32'h0000_0077);
        rd(8'h10, 32'h0000_0003);
        nine <= 1'b1;
        bus(8'h00, 1'b1, 32'h0000_00B8);
        uwt_remote_i.send(9'h055);
        repeat (4) @(posedge ref_clk);
        rd(8'h10, 32'h0000_0000);
        uwt_remote_i.send(9'h15A);
        hold(1, 20);
        rd(8'h04, 32'h0000_005A);
        rd(8'h00, 32'h0000_00FD);
        rd(8'h10, 32'h0000_0001);
        bus(8'h04, 1'b1, 32'h0000_00C3);
        hold(1, 300);
        repeat (8) @(posedge ref_clk);
        chk({23'h0, got}, 32'h0000_01C3);
        // Reset in mid-run with the interrupt still pending
        rst <= 1'b1;
        @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0000_0000);
        rd(8'h00, 32'h0000_0040);
        report_and_stop();
    end
endmodule
